// [hdl/path_trace_cfg.svh]
/*
 * Constants for the path trace buffer: register offsets, reset values,
 * message lengths and persistence counts.
 * Assumes it is included by bare name from the package and the unit.
 */
// Notes on behaviour
// - short select gives 16 bytes, else 64
// - 16-byte sync: msb-set byte goes first
// - 64-byte sync: byte after CR LF goes first
// - sync disabled: buffer fills circularly
// - transmit null sends zeros, else buffer
// - accept after five or three identical messages
// - mismatch changes raise interrupt when enabled
// - unstable changes raise interrupt when enabled
// - count differing messages, unstable at eight
// - buffer select picks receive or transmit buffers
// - mismatch state high while accepted differs expected
// - mismatch event set on change, read clears
// - unstable event set on change, read clears
// - reset: null set, others clear, busy zero
// - busy high from address write until done
// - address write starts indirect read or write
// - receive: capture 0-63, expected 64-127
`ifndef PATH_TRACE_CFG_SVH
`define PATH_TRACE_CFG_SVH

`define PT_OFS_CTRL 8'h48
`define PT_OFS_STAT 8'h49
`define PT_OFS_IADDR 8'h4a
`define PT_OFS_IDATA 8'h4b

`define PT_CTRL_RESET 8'h04
`define PT_STAT_BUSY_POS 7

`define PT_LEN_LONG 64
`define PT_LEN_SHORT 16
`define PT_PERSIST_SHORT 3
`define PT_PERSIST_LONG 5
`define PT_UNSTABLE_LIMIT 8

`define PT_CHAR_CR 8'h0d
`define PT_CHAR_LF 8'h0a

`endif

// [hdl/path_trace_pkg.sv]
/*
 * Types for the path trace buffer: register request, trace byte carrier,
 * control register layout and indirect access state.
 * Assumes path_trace_cfg.svh is on the include path.
 */
package path_trace_pkg;
	`include "path_trace_cfg.svh"

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} trace_byte_t;

	typedef struct packed {
		logic unused;
		logic receive_buffer_select;
		logic trace_unstable_int_en;
		logic trace_mismatch_int_en;
		logic persistence_five_select;
		logic transmit_null_trace;
		logic trace_sync_disable;
		logic short_trace_select;
	} ctrl_t;

	typedef enum logic {ACC_IDLE, ACC_RUN} acc_state_t;
endpackage

// [hdl/path_trace_unit.sv]
/*
 * Path trace buffer: receive capture with alignment, persistence,
 * mismatch and instability detection; transmit trace byte source;
 * indirect buffer access with busy flag.
 * Assumes register strobes, J1 receive bytes and transmit slots are
 * one-cycle pulses synchronous to core_clk.
 */
`timescale 1ns/100ps
`include "path_trace_cfg.svh"
module path_trace_unit #(
	parameter int LongLen = `PT_LEN_LONG,
	parameter int ShortLen = `PT_LEN_SHORT,
	parameter int PersistShort = `PT_PERSIST_SHORT,
	parameter int PersistLong = `PT_PERSIST_LONG,
	parameter int UnstableLimit = `PT_UNSTABLE_LIMIT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire path_trace_pkg::reg_req_t regReq,
	output logic [7:0] regRdData,
	// receive J1 bytes
	input wire path_trace_pkg::trace_byte_t rxTrace,
	// transmit overhead inserter
	input wire logic txSlot,
	output logic [7:0] txTraceByte,
	// interrupt
	output logic interrupt_out_n
);
	import path_trace_pkg::*;

	ctrl_t ctrl_r, ctrl_nxt;
	acc_state_t acc_r, acc_nxt;
	logic [7:0] iaddr_r, iaddr_nxt, idata_r, idata_nxt, rdData_r, rdData_nxt;
	logic [7:0] capBuf_r [LongLen], capBuf_nxt [LongLen];
	logic [7:0] expBuf_r [LongLen], expBuf_nxt [LongLen];
	logic [7:0] accBuf_r [LongLen], accBuf_nxt [LongLen];
	logic [7:0] txBuf_r [LongLen], txBuf_nxt [LongLen];
	logic [5:0] wrIdx_r, wrIdx_nxt, txIdx_r, txIdx_nxt;
	logic [7:0] prev1_r, prev1_nxt, prev2_r, prev2_nxt;
	logic msgDiff_r, msgDiff_nxt;
	logic [2:0] persist_r, persist_nxt;
	logic [3:0] unstCnt_r, unstCnt_nxt;
	logic unstable_r, unstable_nxt, mismatch_r, mismatch_nxt;
	logic mmEv_r, mmEv_nxt, unEv_r, unEv_nxt;
	logic [7:0] txByte_r, txByte_nxt;
	logic statRead, cpuWrite;
	logic [5:0] lastIdx;
	logic [7:0] bufRd;

	// last index of the active message length
	function automatic logic [5:0] msgLast(input logic short);
		msgLast = short ? 6'(ShortLen - 1) : 6'(LongLen - 1);
	endfunction

	// compare accepted against expected over the active length only
	function automatic logic msgDiffer(input logic [7:0] a [LongLen],
		input logic [7:0] b [LongLen], input logic [5:0] last);
		msgDiffer = 1'b0;
		for (int i = 0; i < LongLen; i++) begin
			if (6'(i) <= last && a[i] != b[i]) begin
				msgDiffer = 1'b1;
			end
		end
	endfunction

	// acceptance count chosen by the persistence select
	function automatic logic [2:0] persistTarget(input logic five);
		persistTarget = five ? 3'(PersistLong) : 3'(PersistShort);
	endfunction

	assign lastIdx = msgLast(ctrl_r.short_trace_select);
	assign statRead = regReq.rd && regReq.addr == `PT_OFS_STAT;
	assign cpuWrite = acc_r == ACC_RUN && !iaddr_r[7];

	// indirect read mux; upper transmit half is unused and reads zero
	always_comb begin
		if (ctrl_r.receive_buffer_select) begin
			bufRd = iaddr_r[6] ? expBuf_r[iaddr_r[5:0]] : capBuf_r[iaddr_r[5:0]];
		end else begin
			bufRd = iaddr_r[6] ? 8'h00 : txBuf_r[iaddr_r[5:0]];
		end
	end

	// register port and indirect access sequencing
	always_comb begin
		ctrl_nxt = ctrl_r;
		acc_nxt = acc_r;
		iaddr_nxt = iaddr_r;
		idata_nxt = idata_r;
		rdData_nxt = rdData_r;
		// access completes one cycle after it is started
		if (acc_r == ACC_RUN) begin
			acc_nxt = ACC_IDLE;
			if (iaddr_r[7]) begin
				idata_nxt = bufRd;
			end
		end
		if (regReq.wr) begin
			case (regReq.addr)
				`PT_OFS_CTRL: begin
					ctrl_nxt = ctrl_t'({1'b0, regReq.wdata[6:0]});
				end
				`PT_OFS_IADDR: begin
					iaddr_nxt = regReq.wdata;
					acc_nxt = ACC_RUN;
				end
				`PT_OFS_IDATA: begin
					idata_nxt = regReq.wdata;
				end
				default: begin
				end
			endcase
		end
		if (regReq.rd) begin
			case (regReq.addr)
				`PT_OFS_CTRL: rdData_nxt = {1'b0, ctrl_r[6:0]};
				`PT_OFS_STAT: rdData_nxt = {acc_r == ACC_RUN, 3'h0, unEv_r, unstable_r,
					mmEv_r, mismatch_r};
				`PT_OFS_IADDR: rdData_nxt = iaddr_r;
				`PT_OFS_IDATA: rdData_nxt = idata_r;
				default: rdData_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= ctrl_t'(`PT_CTRL_RESET);
			acc_r <= ACC_IDLE;
			iaddr_r <= 8'h00;
			idata_r <= 8'h00;
			rdData_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			acc_r <= acc_nxt;
			iaddr_r <= iaddr_nxt;
			idata_r <= idata_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	// receive framer, persistence, instability and processor buffer writes
	always_comb begin
		logic [5:0] idx;
		logic diff;
		logic accept;
		idx = wrIdx_r;
		diff = 1'b0;
		accept = 1'b0;
		capBuf_nxt = capBuf_r;
		expBuf_nxt = expBuf_r;
		accBuf_nxt = accBuf_r;
		txBuf_nxt = txBuf_r;
		wrIdx_nxt = wrIdx_r;
		prev1_nxt = prev1_r;
		prev2_nxt = prev2_r;
		msgDiff_nxt = msgDiff_r;
		persist_nxt = persist_r;
		unstCnt_nxt = unstCnt_r;
		unstable_nxt = unstable_r;
		// processor writes first so a same-cycle received byte wins the capture slot
		if (cpuWrite) begin
			if (ctrl_r.receive_buffer_select) begin
				if (iaddr_r[6]) begin
					expBuf_nxt[iaddr_r[5:0]] = idata_r;
				end else begin
					capBuf_nxt[iaddr_r[5:0]] = idata_r;
				end
			end else if (!iaddr_r[6]) begin
				txBuf_nxt[iaddr_r[5:0]] = idata_r;
			end
		end
		if (rxTrace.valid) begin
			// length switch may leave the index past the end; fold it back
			if (idx > lastIdx) begin
				idx = 6'h00;
			end
			if (!ctrl_r.trace_sync_disable) begin
				if (ctrl_r.short_trace_select && rxTrace.data[7]) begin
					idx = 6'h00;
				end
				if (!ctrl_r.short_trace_select && prev2_r == `PT_CHAR_CR &&
					prev1_r == `PT_CHAR_LF) begin
					idx = 6'h00;
				end
			end
			diff = (idx != 6'h00 && msgDiff_r) || rxTrace.data != capBuf_r[idx];
			capBuf_nxt[idx] = rxTrace.data;
			prev2_nxt = prev1_r;
			prev1_nxt = rxTrace.data;
			if (idx == lastIdx) begin
				// a whole message has arrived
				wrIdx_nxt = 6'h00;
				msgDiff_nxt = 1'b0;
				if (diff) begin
					persist_nxt = 3'h1;
					if (unstCnt_r < 4'(UnstableLimit)) begin
						unstCnt_nxt = unstCnt_r + 4'h1;
					end
				end else if (persist_r < persistTarget(ctrl_r.persistence_five_select)) begin
					persist_nxt = persist_r + 3'h1;
				end
				accept = persist_nxt == persistTarget(ctrl_r.persistence_five_select);
				if (accept) begin
					accBuf_nxt = capBuf_nxt;
					unstCnt_nxt = 4'h0;
				end
			end else begin
				wrIdx_nxt = idx + 6'h01;
				msgDiff_nxt = diff;
			end
		end
		// unstable set at the limit, cleared when a message is accepted
		if (accept) begin
			unstable_nxt = 1'b0;
		end else if (unstCnt_nxt >= 4'(UnstableLimit)) begin
			unstable_nxt = 1'b1;
		end
		mismatch_nxt = msgDiffer(accBuf_r, expBuf_r, lastIdx);
		// a state change in the read cycle keeps its event bit set
		mmEv_nxt = (mismatch_nxt != mismatch_r) || (mmEv_r && !statRead);
		unEv_nxt = (unstable_nxt != unstable_r) || (unEv_r && !statRead);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < LongLen; i++) begin
				capBuf_r[i] <= 8'h00;
				expBuf_r[i] <= 8'h00;
				accBuf_r[i] <= 8'h00;
				txBuf_r[i] <= 8'h00;
			end
			wrIdx_r <= 6'h00;
			prev1_r <= 8'h00;
			prev2_r <= 8'h00;
			msgDiff_r <= 1'b0;
			persist_r <= 3'h0;
			unstCnt_r <= 4'h0;
			unstable_r <= 1'b0;
			mismatch_r <= 1'b0;
			mmEv_r <= 1'b0;
			unEv_r <= 1'b0;
		end else begin
			capBuf_r <= capBuf_nxt;
			expBuf_r <= expBuf_nxt;
			accBuf_r <= accBuf_nxt;
			txBuf_r <= txBuf_nxt;
			wrIdx_r <= wrIdx_nxt;
			prev1_r <= prev1_nxt;
			prev2_r <= prev2_nxt;
			msgDiff_r <= msgDiff_nxt;
			persist_r <= persist_nxt;
			unstCnt_r <= unstCnt_nxt;
			unstable_r <= unstable_nxt;
			mismatch_r <= mismatch_nxt;
			mmEv_r <= mmEv_nxt;
			unEv_r <= unEv_nxt;
		end
	end

	// transmit byte per J1 slot; no lock against rewrites, software must null first
	always_comb begin
		txIdx_nxt = txIdx_r;
		txByte_nxt = txByte_r;
		if (txSlot) begin
			txByte_nxt = ctrl_r.transmit_null_trace ? 8'h00 : txBuf_r[txIdx_r];
			txIdx_nxt = txIdx_r >= lastIdx ? 6'h00 : txIdx_r + 6'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txIdx_r <= 6'h00;
			txByte_r <= 8'h00;
		end else begin
			txIdx_r <= txIdx_nxt;
			txByte_r <= txByte_nxt;
		end
	end

	assign regRdData = rdData_r;
	assign txTraceByte = txByte_r;
	// enabled events drive the shared active-low interrupt
	assign interrupt_out_n = !((mmEv_r && ctrl_r.trace_mismatch_int_en) ||
		(unEv_r && ctrl_r.trace_unstable_int_en));
endmodule // path_trace_unit

// [tb/path_trace_checker.sv]
/* port assertions for the path trace unit
   assumes a bind into path_trace_unit, one clock */
`timescale 1ns/100ps
module path_trace_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// watched ports
	input wire path_trace_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdData,
	input wire path_trace_pkg::trace_byte_t rxTrace,
	input wire logic txSlot,
	input wire logic [7:0] txTraceByte,
	input wire logic interrupt_out_n
);
	import path_trace_pkg::*;
	logic [7:0] ctl_r, ctl_nxt;
	logic [2:0] quiet_r, quiet_nxt;
	wire stRd = regReq.rd && regReq.addr == 8'h49;
	// control shadow; quiet counts cycles with no rx byte and no write
	always_comb begin
		ctl_nxt = ctl_r;
		if (regReq.wr && regReq.addr == 8'h48) ctl_nxt = {1'b0, regReq.wdata[6:0]};
		quiet_nxt = rxTrace.valid || regReq.wr ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= 8'h04;
			quiet_r <= 3'h0;
		end else begin
			ctl_r <= ctl_nxt;
			quiet_r <= quiet_nxt;
		end
	end
	sequence addrWr;
		regReq.wr && regReq.addr == 8'h4a;
	endsequence
	sequence dataWr;
		regReq.wr && regReq.addr == 8'h4b;
	endsequence
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_null_zero: assert property (txSlot && ctl_r[2] |=> txTraceByte == 8'h00) // null
		else $error("tx byte not zero under null");
	chk_tx_hold: assert property (!txSlot |=> $stable(txTraceByte)) // slots
		else $error("tx byte moved without slot");
	chk_ctrl_read: assert property ( // readback
		regReq.rd && regReq.addr == 8'h48 |=> regRdData == $past(ctl_r))
		else $error("control readback wrong");
	chk_busy_done: assert property (addrWr ##2 stRd |=> !regRdData[7]) // busy
		else $error("busy still high");
	chk_busy_high: assert property (addrWr ##1 stRd |=> regRdData[7]) // busy
		else $error("busy not set after address write");
	chk_idata_back: assert property ( // data
		dataWr ##2 (regReq.rd && regReq.addr == 8'h4b) |=> regRdData == $past(regReq.wdata, 3))
		else $error("indirect data not kept");
	chk_int_off: assert property (!ctl_r[4] && !ctl_r[5] |-> interrupt_out_n)
		else $error("interrupt without enable");
	chk_int_clear: assert property (stRd && quiet_r > 3'h3 |=> interrupt_out_n)
		else $error("interrupt kept after status read");
	chk_int_fall: assert property ($fell(interrupt_out_n) |-> quiet_r < 3'h4) // cause
		else $error("interrupt with no cause");
endmodule // path_trace_checker
bind path_trace_unit path_trace_checker chk (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq),
	.regRdData(regRdData), .rxTrace(rxTrace), .txSlot(txSlot), .txTraceByte(txTraceByte),
	.interrupt_out_n(interrupt_out_n));

// [tb/trace_source.sv]
/* far-end model sending J1 trace bytes
   assumes the bench holds go until busy rises */
`timescale 1ns/100ps
module trace_source (
	// clock
	input wire logic core_clk,
	// message request
	input wire logic go,
	input wire logic shortLen,
	input wire logic [7:0] pat,
	input wire logic [5:0] phase,
	input wire logic [2:0] reps,
	// trace stream
	output path_trace_pkg::trace_byte_t rxTrace,
	output logic busy
);
	import path_trace_pkg::*;
	int len;
	int n;
	// msb marks the start of short messages, cr lf ends long ones
	function automatic logic [7:0] msgByte(input logic s, input logic [7:0] p, input int k);
		if (s) return {k == 0, p[6:0] + 7'(k)};
		return k == 62 ? 8'h0d : k == 63 ? 8'h0a : {1'b0, p[6:0] + 7'(k)};
	endfunction
	// partial message from phase, then whole ones; idle data inverted
	initial begin
		rxTrace = '0;
		busy = 1'b0;
		forever begin
			@(posedge core_clk);
			if (go) begin
				busy = 1'b1;
				len = shortLen ? 16 : 64;
				n = len * reps + (phase != 6'h00 ? len : 0);
				for (int k = phase; k < n; k++) begin
					@(negedge core_clk);
					rxTrace = '{1'b1, msgByte(shortLen, pat, k % len)};
					if (k % 4 != 3) begin // mostly slow, some back to back
						@(negedge core_clk);
						rxTrace = '{1'b0, ~rxTrace.data};
					end
				end
				@(negedge core_clk);
				rxTrace = '{1'b0, ~rxTrace.data};
				busy = 1'b0;
			end
		end
	end
endmodule // trace_source

// [tb/path_trace_unit_tb.sv]
/* self-checking bench for path_trace_unit
   assumes trace_source feeds the receive stream */
`timescale 1ns/100ps
module path_trace_unit_tb;
	import path_trace_pkg::*;
	typedef struct packed {
		logic [7:0] ctl;
		logic [5:0] ph;
		logic [2:0] reps;
		logic [7:0] st;
	} row_t;
	// capture cases: control, phase, repeats, status
	row_t rows [6] = '{'{8'h11, 6'h03, 3'h3, 8'h03}, '{8'h11, 6'h03, 3'h2, 8'h00},
		'{8'h19, 6'h03, 3'h5, 8'h03}, '{8'h19, 6'h03, 3'h4, 8'h00},
		'{8'h10, 6'h05, 3'h3, 8'h03}, '{8'h13, 6'h00, 3'h3, 8'h03}};
	logic core_clk, rst_n, txSlot, go, sl, busy, intN;
	logic [7:0] rdData, txByte, pat, v;
	logic [5:0] ph;
	logic [2:0] reps;
	reg_req_t regReq;
	trace_byte_t rxTrace;
	int errorCnt, samplesChecked, cyc;
	path_trace_unit DUT (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(rdData),
		.rxTrace(rxTrace), .txSlot(txSlot), .txTraceByte(txByte), .interrupt_out_n(intN));
	trace_source src (.core_clk(core_clk), .go(go), .shortLen(sl), .pat(pat), .phase(ph),
		.reps(reps), .rxTrace(rxTrace), .busy(busy));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// hang guard, far above the few thousand cycles needed
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errorCnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			errorCnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one register cycle plus an idle one, read data left in v
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		regReq = '{w, !w, a, d};
		@(negedge core_clk);
		v = rdData;
		regReq = '0;
		@(negedge core_clk);
	endtask
	task automatic iwr(input logic [6:0] a, input logic [7:0] d);
		bus(1'b1, 8'h4b, d);
		bus(1'b1, 8'h4a, {1'b0, a});
	endtask
	task automatic ird(input logic [6:0] a);
		bus(1'b1, 8'h4a, {1'b1, a});
		bus(1'b0, 8'h49, 8'h00);
		check("busy", 8'h00, v & 8'h80);
		bus(1'b0, 8'h4b, 8'h00);
	endtask
	task automatic send(input logic s, input logic [7:0] p, input logic [5:0] f, input logic [2:0] r);
		sl = s;
		pat = p;
		ph = f;
		reps = r;
		go = 1'b1;
		wait (busy);
		@(negedge core_clk);
		go = 1'b0;
		wait (!busy);
		repeat (6) @(negedge core_clk);
	endtask
	task automatic reset();
		rst_n = 1'b0;
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
	endtask
	initial begin
		regReq = '0;
		txSlot = 1'b0;
		go = 1'b0;
		foreach (rows[i]) begin
			reset();
			bus(1'b1, 8'h48, rows[i].ctl);
			send(rows[i].ctl[0], 8'h21, rows[i].ph, rows[i].reps);
			check("int", {7'h0, rows[i].st == 8'h00}, {7'h0, intN});
			bus(1'b0, 8'h49, 8'h00);
			check("status", rows[i].st, v);
			bus(1'b0, 8'h49, 8'h00);
			check("status", rows[i].st & 8'h05, v);
			check("int", 8'h01, {7'h0, intN});
			bus(1'b1, 8'h48, rows[i].ctl | 8'h40);
			ird(7'h00);
			check("cap0", src.msgByte(rows[i].ctl[0], 8'h21, 0), v);
			ird(rows[i].ctl[0] ? 7'h0f : 7'h3f);
			check("capend", src.msgByte(rows[i].ctl[0], 8'h21, rows[i].ctl[0] ? 15 : 63), v);
		end
		reset();
		bus(1'b0, 8'h48, 8'h00);
		check("ctrl", 8'h04, v);
		bus(1'b1, 8'h4b, 8'h5a);
		bus(1'b0, 8'h4b, 8'h00);
		check("idata", 8'h5a, v);
		// busy must read high in the cycle right after the address write
		regReq = '{1'b1, 1'b0, 8'h4a, 8'h80};
		@(negedge core_clk);
		bus(1'b0, 8'h49, 8'h00);
		check("busy", 8'h80, v & 8'h80);
		// transmit buffer loaded while null is set
		for (int k = 0; k < 16; k++) iwr(7'(k), 8'ha0 + 8'(k));
		iwr(7'h40, 8'hee);
		ird(7'h40);
		check("txhole", 8'h00, v);
		bus(1'b1, 8'h48, 8'h01);
		txSlot = 1'b1;
		for (int k = 0; k < 18; k++) begin
			@(negedge core_clk);
			check("tx", 8'ha0 + 8'(k % 16), txByte);
		end
		bus(1'b1, 8'h48, 8'h05);
		check("txnull", 8'h00, txByte);
		txSlot = 1'b0;
		// expected page, then unstable entry and exit
		bus(1'b1, 8'h48, 8'h41);
		for (int k = 0; k < 16; k++) iwr(7'h40 + 7'(k), src.msgByte(1'b1, 8'h21, k));
		bus(1'b0, 8'h49, 8'h00);
		check("status", 8'h03, v);
		ird(7'h40);
		check("exp0", src.msgByte(1'b1, 8'h21, 0), v);
		send(1'b1, 8'h21, 6'h03, 3'h3);
		bus(1'b0, 8'h49, 8'h00);
		check("status", 8'h02, v);
		bus(1'b1, 8'h48, 8'h61);
		// seven differing messages stay stable, the eighth tips it over
		for (int k = 0; k < 7; k++) send(1'b1, 8'h30 + 8'(k), 6'h00, 3'h1);
		bus(1'b0, 8'h49, 8'h00);
		check("status", 8'h00, v);
		send(1'b1, 8'h37, 6'h00, 3'h1);
		check("int", 8'h00, {7'h0, intN});
		bus(1'b0, 8'h49, 8'h00);
		check("status", 8'h0c, v);
		send(1'b1, 8'h44, 6'h01, 3'h3);
		bus(1'b0, 8'h49, 8'h00);
		check("status", 8'h0b, v);
		report_and_stop();
	end
endmodule // path_trace_unit_tb
